// ---- ext_irq_flag_assertions.sv ----
// port assertions for the pin request-flag block
`default_nettype none
module ext_irq_flag_assertions (
  // clock, reset, register port, pins, flags
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic [7:0] wake_pin,
  input wire logic [4:0] irq_request_flag_reg,
  input wire logic [7:0] wake_request_flag_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic wi, ww, wf, fw;
  logic [4:0] q;
  logic [7:0] k, fn, ex;
  assign q = irq_request_flag_reg;
  assign k = wake_request_flag_reg;
  assign wi = wr && addr == 4'h0;
  assign ww = wr && addr == 4'h1;
  assign wf = wr && addr == 4'h4;
  assign fw = wf || wr && addr inside {4'h2, 4'h3};
  // shadow of the wake function byte, so a spurious set can be predicted
  always_ff @(posedge clk or negedge nrst)
    if (!nrst) {fn, ex} <= 16'h0000;
    else if (wf) {fn, ex} <= {wdata, wdata & ~fn & ~wake_pin};
  reset_clear_a: assert property ($rose(nrst) |-> q == 5'h00 && k == 8'h00) else $error("flag after reset");
  irq_keep_a: assert property (wi |=> (~q & $past(q) & $past(wdata[4:0])) == 5'h00) else $error("irq lost");
  wake_keep_a: assert property (ww |=> (~k & $past(k) & $past(wdata)) == 8'h00) else $error("wake lost");
  irq_fall_a: assert property (|(~q & $past(q)) |-> $past(wi)) else $error("irq fell");
  wake_fall_a: assert property (|(~k & $past(k)) |-> $past(ww)) else $error("wake fell");
  clear_hold_a: assert property (wi && $past(fw) |=> (~q & $past(q)) == 5'h00) else $error("early clear");
  clear_late_a: assert property (ww && !$past(fw) && !$past(fw, 2) && !$past(fw, 3) |=>
    (k & ~$past(wdata)) == 8'h00) else $error("clear ignored");
  wake_switch_a: assert property (wf |-> ##[2:4] (k & ex) == ex) else $error("no switch set");
endmodule // ext_irq_flag_assertions
bind ext_pin_irq_flag_logic ext_irq_flag_assertions chk (.clk, .nrst, .addr, .wdata, .wr, .wake_pin,
  .irq_request_flag_reg, .wake_request_flag_reg);
`default_nettype wire

// ---- ext_irq_pkg.sv ----
// shared constants and carriers for the external pin request-flag block
`default_nettype none
package ext_irq_pkg;
  localparam int irq_lines = 5;
  localparam int wake_lines = 8;
  // register map of the plain register port
  localparam logic [3:0] addr_irq_flag = 4'h0;
  localparam logic [3:0] addr_wake_flag = 4'h1;
  localparam logic [3:0] addr_port_func_a = 4'h2;
  localparam logic [3:0] addr_port_func_b = 4'h3;
  localparam logic [3:0] addr_wake_func = 4'h4;
  localparam logic [3:0] addr_irq_edge = 4'h5;
  localparam logic [3:0] addr_wake_edge = 4'h6;
  // field positions: irq lines 0..3 sit in function reg a, line 4 in reg b bit 0
  localparam int func_a_lines = 4;
  localparam int func_b_line = 4;
  localparam logic [7:0] reset_byte = 8'h00;
  localparam logic [7:0] unmapped_byte = 8'h00;
  // one less than the cycles after a function register write during which a flag clear is ignored
  localparam logic [1:0] clear_hold_cycles = 2'h1;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage : ext_irq_pkg
`default_nettype wire

// ---- ext_pin_irq_flag_logic.sv ----
// request flags for five irq pins and eight wakeup pins
`default_nettype none
// Contract
// - irq flag sets when function goes 0 to 1 with pin low, falling edge chosen.
// - irq flag sets when function goes 1 to 0 with pin low, rising edge chosen.
// - wake flag sets when function goes 0 to 1 with pin low.
// - clear written right after function register write is ignored; later clear works.
// - a flag set during read-modify-write is lost if written back as zero.
// - flags clear only by writing zero; writing one keeps them.
// - wake edge select 0 is falling, reset value, 1 is rising.
// - irq pins detect the selected edge and set flags when in interrupt function.
module ext_pin_irq_flag_logic (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // pins
  input wire logic [ext_irq_pkg::irq_lines-1:0] ext_irq_pin,
  input wire logic [ext_irq_pkg::wake_lines-1:0] wake_pin,
  // request flags to the interrupt controller
  output logic [ext_irq_pkg::irq_lines-1:0] irq_request_flag_reg,
  output logic [ext_irq_pkg::wake_lines-1:0] wake_request_flag_reg
);
  ext_irq_pkg::reg_req_t req;
  logic [7:0] port_function_reg_a, next_func_a;
  logic [7:0] port_function_reg_b, next_func_b;
  logic [7:0] wake_pin_function_reg, next_wake_func;
  logic [7:0] irq_edge_select_reg, next_irq_edge;
  logic [7:0] wake_line_edge_select, next_wake_edge;
  logic [ext_irq_pkg::irq_lines-1:0] next_irq_flag, irq_hit, irq_func;
  logic [ext_irq_pkg::wake_lines-1:0] next_wake_flag, wake_hit;
  logic [1:0] clear_hold, next_clear_hold;
  // last wake function byte, so a switch with the pin low sets the flag whatever edge is chosen
  logic [ext_irq_pkg::wake_lines-1:0] wake_func_seen, next_wake_func_seen, wake_switch;
  logic [7:0] next_rdata;
  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
  assign irq_func = {port_function_reg_b[0], port_function_reg_a[ext_irq_pkg::func_a_lines-1:0]};
  function automatic logic is_wr(input ext_irq_pkg::reg_req_t r, input logic [3:0] a);
    is_wr = r.wr && (r.addr == a);
  endfunction
  pin_edge_detect #(.width(ext_irq_pkg::irq_lines)) u_irq_edge (
    .clk(clk),
    .nrst(nrst),
    .pin(ext_irq_pin),
    .func(irq_func),
    .edge_sel(irq_edge_select_reg[ext_irq_pkg::irq_lines-1:0]),
    .hit(irq_hit)
  );
  pin_edge_detect #(.width(ext_irq_pkg::wake_lines)) u_wake_edge (
    .clk(clk),
    .nrst(nrst),
    .pin(wake_pin),
    .func(wake_pin_function_reg),
    .edge_sel(wake_line_edge_select),
    .hit(wake_hit)
  );
  always_comb begin
    next_func_a = port_function_reg_a;
    next_func_b = port_function_reg_b;
    next_wake_func = wake_pin_function_reg;
    next_irq_edge = irq_edge_select_reg;
    next_wake_edge = wake_line_edge_select;
    next_clear_hold = (clear_hold != 2'h0) ? clear_hold - 2'h1 : 2'h0;
    next_wake_func_seen = wake_pin_function_reg;
    if (is_wr(req, ext_irq_pkg::addr_port_func_a)) next_func_a = req.wdata;
    if (is_wr(req, ext_irq_pkg::addr_port_func_b)) next_func_b = req.wdata;
    if (is_wr(req, ext_irq_pkg::addr_wake_func)) next_wake_func = req.wdata;
    if (is_wr(req, ext_irq_pkg::addr_irq_edge)) next_irq_edge = req.wdata;
    if (is_wr(req, ext_irq_pkg::addr_wake_edge)) next_wake_edge = req.wdata;
    if (is_wr(req, ext_irq_pkg::addr_port_func_a) || is_wr(req, ext_irq_pkg::addr_port_func_b) ||
        is_wr(req, ext_irq_pkg::addr_wake_func)) begin
      // the edge from the switch lands a cycle later, so an immediate clear must not win
      next_clear_hold = ext_irq_pkg::clear_hold_cycles + 2'h1;
    end
  end
  always_comb begin
    next_irq_flag = irq_request_flag_reg;
    next_wake_flag = wake_request_flag_reg;
    wake_switch = wake_pin_function_reg & ~wake_func_seen & ~wake_pin;
    if (is_wr(req, ext_irq_pkg::addr_irq_flag) && clear_hold == 2'h0) begin
      next_irq_flag = irq_request_flag_reg & req.wdata[ext_irq_pkg::irq_lines-1:0];
    end
    if (is_wr(req, ext_irq_pkg::addr_wake_flag) && clear_hold == 2'h0) begin
      next_wake_flag = wake_request_flag_reg & req.wdata;
    end
    // set wins over a clear in the same cycle
    next_irq_flag = next_irq_flag | irq_hit;
    next_wake_flag = next_wake_flag | wake_hit | wake_switch;
  end
  always_comb begin
    next_rdata = ext_irq_pkg::unmapped_byte;
    if (req.rd) begin
      case (req.addr)
        ext_irq_pkg::addr_irq_flag: next_rdata = {3'h0, irq_request_flag_reg};
        ext_irq_pkg::addr_wake_flag: next_rdata = wake_request_flag_reg;
        ext_irq_pkg::addr_port_func_a: next_rdata = port_function_reg_a;
        ext_irq_pkg::addr_port_func_b: next_rdata = port_function_reg_b;
        ext_irq_pkg::addr_wake_func: next_rdata = wake_pin_function_reg;
        ext_irq_pkg::addr_irq_edge: next_rdata = irq_edge_select_reg;
        ext_irq_pkg::addr_wake_edge: next_rdata = wake_line_edge_select;
        default: next_rdata = ext_irq_pkg::unmapped_byte;
      endcase
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port_function_reg_a <= ext_irq_pkg::reset_byte;
      port_function_reg_b <= ext_irq_pkg::reset_byte;
      wake_pin_function_reg <= ext_irq_pkg::reset_byte;
      irq_edge_select_reg <= ext_irq_pkg::reset_byte;
      wake_line_edge_select <= ext_irq_pkg::reset_byte;
      clear_hold <= 2'h0;
      wake_func_seen <= '0;
    end else begin
      port_function_reg_a <= next_func_a;
      port_function_reg_b <= next_func_b;
      wake_pin_function_reg <= next_wake_func;
      irq_edge_select_reg <= next_irq_edge;
      wake_line_edge_select <= next_wake_edge;
      clear_hold <= next_clear_hold;
      wake_func_seen <= next_wake_func_seen;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_request_flag_reg <= '0;
      wake_request_flag_reg <= '0;
      rdata <= ext_irq_pkg::reset_byte;
    end else begin
      irq_request_flag_reg <= next_irq_flag;
      wake_request_flag_reg <= next_wake_flag;
      rdata <= next_rdata;
    end
  end
endmodule : ext_pin_irq_flag_logic
`default_nettype wire

// ---- ext_pin_irq_flag_logic_tb.sv ----
// bench for the pin request-flag block
`default_nettype none
module ext_pin_irq_flag_logic_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, nrst = 1'h0, wr = 1'h0, rd = 1'h0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic [12:0] lvl = 13'h0000, pins;
  logic [4:0] irq_flags;
  logic [7:0] wake_flags;
  int miscompares, num_checks, cyc;
  pin_source src (.clk, .lvl, .pins);
  ext_pin_irq_flag_logic DUT (.clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .ext_irq_pin(pins[4:0]),
    .wake_pin(pins[12:5]), .irq_request_flag_reg(irq_flags), .wake_request_flag_reg(wake_flags));
  initial forever #50 clk = ~clk;
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ceiling well above the roughly 85 cycles used
  always @(posedge clk) if (++cyc == 1000) begin
    miscompares++;
    conclude();
  end
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk);
      wr <= 1'h0;
      rd <= 1'h0;
    end
  endtask
  task automatic chk(input logic [3:0] a, input logic [7:0] e);
    bus(1'h0, a, 8'h00);
    idle(1);
    #1 num_checks++;
    if (rdata !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, rdata, e);
    end
  endtask
  task automatic pin(input logic [12:0] v);
    @(posedge clk);
    lvl <= v;
    idle(3);
  endtask
  task automatic t_wake();
    bus(1'h1, 4'h4, 8'hff);
    bus(1'h1, 4'h1, 8'h00);
    idle(4);
    chk(4'h1, 8'hff);
    bus(1'h1, 4'h1, 8'hfe);
    chk(4'h1, 8'hfe);
    bus(1'h1, 4'h1, 8'hff);
    chk(4'h1, 8'hfe);
  endtask
  task automatic t_irq();
    bus(1'h1, 4'h2, 8'h0f);
    bus(1'h1, 4'h3, 8'h01);
    idle(4);
    chk(4'h0, 8'h1f);
    bus(1'h1, 4'h0, 8'h00);
    bus(1'h1, 4'h5, 8'h1f);
    bus(1'h1, 4'h2, 8'h00);
    bus(1'h1, 4'h3, 8'h00);
    bus(1'h1, 4'h0, 8'h00);
    idle(4);
    chk(4'h0, 8'h1f);
  endtask
  task automatic t_edge();
    pin(13'h1fff);
    bus(1'h1, 4'h0, 8'h00);
    bus(1'h1, 4'h1, 8'h00);
    bus(1'h1, 4'h2, 8'h0f);
    bus(1'h1, 4'h3, 8'h01);
    bus(1'h1, 4'h6, 8'hff);
    idle(4);
    chk(4'h0, 8'h00);
    pin(13'h0000);
    chk(4'h0, 8'h00);
    chk(4'h1, 8'h00);
    pin(13'h1fff);
    chk(4'h0, 8'h1f);
    chk(4'h1, 8'hff);
    num_checks++;
    if ({wake_flags, irq_flags} !== 13'h1fff) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, {wake_flags, irq_flags}, 13'h1fff);
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'h1;
    for (int a = 0; a < 8; a++) chk(4'(a), 8'h00);
    t_wake();
    t_irq();
    t_edge();
    conclude();
  end
endmodule // ext_pin_irq_flag_logic_tb
`default_nettype wire

// ---- pin_edge_detect.sv ----
// edge detector for one group of request lines
`default_nettype none
module pin_edge_detect #(
  parameter int width = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // levels
  input wire logic [width-1:0] pin,
  input wire logic [width-1:0] func,
  input wire logic [width-1:0] edge_sel,
  // detected events
  output logic [width-1:0] hit
);
  logic [width-1:0] level;
  logic [width-1:0] prev;
  logic [width-1:0] next_prev;
  // a pin outside interrupt function looks high, so switching function is a real edge here
  assign level = pin | ~func;
  always_comb begin
    next_prev = level;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev <= '1;
    end else begin
      prev <= next_prev;
    end
  end
  // falling when select is 0, rising when 1
  assign hit = (prev & ~level & ~edge_sel) | (~prev & level & edge_sel);
endmodule : pin_edge_detect
`default_nettype wire

// ---- pin_source.sv ----
// far-side model: sources driving the irq and wakeup pins
`default_nettype none
module pin_source (
  // clock, commanded levels, pins
  input wire logic clk,
  input wire logic [12:0] lvl,
  output var logic [12:0] pins = 13'h0000
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge clk) pins <= lvl;
endmodule // pin_source
`default_nettype wire
